// ===== dv/brs_alu_model.sv
`timescale 1ns/100ps
module brs_alu_model (
  input wire logic [31:0] opnd_a, // First addend
  input wire logic [31:0] opnd_b, // Second addend
  output logic carry_in_msb, // Carry into bit 31
  output logic carry_out_msb // Carry out of bit 31
);
  logic [31:0] low_sum;
  // Adder of the execution unit, split at the msb
  always_comb begin
    low_sum = {1'b0, opnd_a[30:0]} + {1'b0, opnd_b[30:0]};
    carry_in_msb = low_sum[31];
    carry_out_msb = (opnd_a[31] & opnd_b[31]) |
      ((opnd_a[31] ^ opnd_b[31]) & low_sum[31]);
  end
endmodule : brs_alu_model

// ===== dv/tb_branch_and_fixed_point_sprs.sv
`timescale 1ns/100ps
module tb_branch_and_fixed_point_sprs;
  logic core_clk = 1'b0, rst_n = 1'b0, user_mode = 1'b0;
  logic spr_wr_en = 1'b0, spr_rd_en = 1'b0, br_dec_ctr = 1'b0;
  logic br_link_en = 1'b0, ov_upd = 1'b0, ov_own_rule = 1'b0;
  logic ov_own_val = 1'b0, ca_upd = 1'b0, ca_own_rule = 1'b0;
  logic ca_own_val = 1'b0, rec_form = 1'b0, mcrxr_en = 1'b0;
  logic [3:0] spr_sel = 4'h0, cond_field, s;
  logic [31:0] spr_wdata = 32'h0, br_next_addr = 32'h0;
  logic [31:0] opnd_a = 32'h0, opnd_b = 32'h0;
  logic [31:0] spr_rdata, ctr_target, link_target, v, vals[4], sv[8];
  logic spr_rd_valid, priv_fault, loop_count_zero, carry_in_msb;
  logic carry_out_msb, cond_valid, cr0_so, cr0_valid, so_flag, ov_flag;
  logic ca_flag, eso, eov, eca;
  logic [brs_pkg::TBC_W-1:0] string_byte_count;
  integer seed;
  int fails = 0, samples_checked = 0, i;

  brs_branch_fx_sprs u_dut (.core_clk, .rst_n, .user_mode, .spr_wr_en,
    .spr_rd_en, .spr_sel, .spr_wdata, .spr_rdata, .spr_rd_valid,
    .priv_fault, .br_dec_ctr, .br_link_en, .br_next_addr, .ctr_target,
    .link_target, .loop_count_zero, .ov_upd, .ov_own_rule, .ov_own_val,
    .carry_in_msb, .carry_out_msb, .ca_upd, .ca_own_rule, .ca_own_val,
    .rec_form, .mcrxr_en, .cond_field, .cond_valid, .cr0_so, .cr0_valid,
    .so_flag, .ov_flag, .ca_flag, .string_byte_count);
  brs_alu_model u_alu (.opnd_a, .opnd_b, .carry_in_msb, .carry_out_msb);

  // 200 MHz core clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // Signed overflow worked out from operand signs, not from carries
  function automatic logic add_ov(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] r;
    r = a + b;
    return (a[31] == b[31]) && (r[31] != a[31]);
  endfunction : add_ov

  function automatic logic add_ca(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] r;
    r = {1'b0, a} + {1'b0, b};
    return r[32];
  endfunction : add_ca

  // Reserved flag bits read back as zero
  function automatic logic [31:0] fx_view(input logic [31:0] w);
    return w & 32'hE000_007F;
  endfunction : fx_view

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // One-cycle move request; caller waits before the next one
  task automatic spr(input logic w, input logic um, input logic [3:0] sel,
                     input logic [31:0] d);
    spr_wr_en = w;
    spr_rd_en = ~w;
    user_mode = um;
    spr_sel = sel;
    spr_wdata = d;
    @(negedge core_clk);
    spr_wr_en = 1'b0;
    spr_rd_en = 1'b0;
  endtask : spr

  task automatic wr(input logic um, input logic [3:0] sel,
                    input logic [31:0] d, input logic flt);
    spr(1'b1, um, sel, d);
    chk1(priv_fault, flt);
    @(negedge core_clk);
  endtask : wr

  task automatic rd(input logic um, input logic [3:0] sel,
                    input logic [31:0] exp);
    spr(1'b0, um, sel, 32'h0);
    chk1(priv_fault, 1'b0);
    @(negedge core_clk);
    chk1(spr_rd_valid, 1'b1);
    chk32(spr_rdata, exp);
  endtask : rd

  task automatic deny(input logic [3:0] sel);
    spr(1'b0, 1'b1, sel, 32'h0);
    chk1(priv_fault, 1'b1);
    @(negedge core_clk);
    chk1(spr_rd_valid, 1'b0);
  endtask : deny

  task automatic end_sim;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Watchdog, far beyond the 160 or so cycles the tests need
  initial begin
    #20000;
    fails++;
    end_sim();
  end

  // Main sequence, inputs changed at falling edges
  initial begin
    seed = 32'he6fa;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk1(loop_count_zero, 1'b1);
    chk1(so_flag, 1'b0);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      vals[i] = $random(seed);
      wr(1'b1, i[3:0], vals[i], 1'b0);
      v = (i == 2) ? fx_view(vals[i]) : vals[i];
      rd(1'b1, i[3:0], v);
    end
    chk32(ctr_target, vals[0]);
    chk32(link_target, {vals[1][31:2], 2'b00});
    chk1(so_flag, vals[2][31]);
    chk1(ov_flag, vals[2][30]);
    chk1(ca_flag, vals[2][29]);
    chk32({25'h0, string_byte_count}, {25'h0, vals[2][6:0]});
    rd(1'b1, 4'h5, 32'h0);
    $display("user register test done");
    for (i = 0; i < 8; i++) begin
      sv[i] = $random(seed);
      wr(1'b0, 4'h8 + i[3:0], sv[i], 1'b0);
    end
    for (i = 0; i < 8; i++) begin
      s = 4'h8 + i[3:0];
      wr(1'b1, s, ~sv[i], 1'b1);
      if (i < 4) deny(s);
      else rd(1'b1, s, sv[i]);
      rd(1'b0, s, sv[i]);
    end
    $display("scratch test done");
    wr(1'b0, brs_pkg::SEL_LOOP_COUNT, 32'h2, 1'b0);
    // Two decrementing branches back to back
    br_dec_ctr = 1'b1;
    @(negedge core_clk);
    chk32(ctr_target, 32'h1);
    chk1(loop_count_zero, 1'b0);
    @(negedge core_clk);
    br_dec_ctr = 1'b0;
    chk1(loop_count_zero, 1'b1);
    v = $random(seed);
    br_next_addr = v;
    br_link_en = 1'b1;
    @(negedge core_clk);
    br_link_en = 1'b0;
    chk32(link_target, {v[31:2], 2'b00});
    rd(1'b1, brs_pkg::SEL_RETURN_LINK, v);
    $display("branch test done");
    wr(1'b0, brs_pkg::SEL_FIXED_POINT_FLAGS, 32'hC000_0000, 1'b0);
    chk1(so_flag, 1'b1);
    wr(1'b0, brs_pkg::SEL_FIXED_POINT_FLAGS, 32'h4000_0000, 1'b0);
    chk1(so_flag, 1'b0);
    chk1(ov_flag, 1'b1);
    eso = 1'b0;
    eov = 1'b1;
    eca = 1'b0;
    // Random arithmetic forms; first two are overflow corner cases
    for (i = 0; i < 48; i++) begin
      if (i < 2) begin
        opnd_a = (i == 0) ? 32'h7FFF_FFFF : 32'h8000_0000;
        opnd_b = (i == 0) ? 32'h0000_0001 : 32'h8000_0000;
        v = 32'h7;
      end else begin
        opnd_a = $random(seed);
        opnd_b = $random(seed);
        v = $random(seed);
      end
      ov_upd = v[0];
      ca_upd = v[1];
      rec_form = v[2];
      if (v[0]) eov = add_ov(opnd_a, opnd_b);
      if (v[1]) eca = add_ca(opnd_a, opnd_b);
      eso = eso | (v[0] & eov);
      @(negedge core_clk);
      chk1(ov_flag, eov);
      chk1(ca_flag, eca);
      chk1(so_flag, eso);
      chk1(cr0_valid, v[2]);
      if (v[2]) chk1(cr0_so, eso);
    end
    // Own rules override the carry chain in both flags
    opnd_a = 32'hFFFF_FFFF;
    opnd_b = 32'hFFFF_FFFF;
    ov_upd = 1'b1;
    ca_upd = 1'b1;
    rec_form = 1'b0;
    ov_own_rule = 1'b1;
    ov_own_val = 1'b1;
    ca_own_rule = 1'b1;
    @(negedge core_clk);
    ov_upd = 1'b0;
    ca_upd = 1'b0;
    chk1(ov_flag, 1'b1);
    chk1(ca_flag, 1'b0);
    chk1(so_flag, 1'b1);
    mcrxr_en = 1'b1;
    @(negedge core_clk);
    mcrxr_en = 1'b0;
    chk1(cond_valid, 1'b1);
    chk32({28'h0, cond_field}, 32'hC);
    chk32({29'h0, so_flag, ov_flag, ca_flag}, 32'h0);
    $display("flags test done");
    end_sim();
  end
endmodule : tb_branch_and_fixed_point_sprs

// ===== src/brs_branch_fx_sprs.sv
`timescale 1ns/100ps
module brs_branch_fx_sprs (
  input wire logic core_clk, // Core clock, 200 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic user_mode, // Issuing instruction runs in user state
  input wire logic spr_wr_en, // Move-to request
  input wire logic spr_rd_en, // Move-from request
  input wire logic [3:0] spr_sel, // Register select code
  input wire logic [31:0] spr_wdata, // Move-to source word
  output logic [31:0] spr_rdata, // Move-from result
  output logic spr_rd_valid, // Result pulse, two cycles after request
  output logic priv_fault, // Privilege violation pulse
  input wire logic br_dec_ctr, // Decrementing conditional branch
  input wire logic br_link_en, // Branch with link-enable bit set
  input wire logic [31:0] br_next_addr, // Address after the branch
  output logic [31:0] ctr_target, // Branch-to-counter target
  output logic [31:0] link_target, // Branch-to-link target, word aligned
  output logic loop_count_zero, // Loop count now equals zero
  input wire logic ov_upd, // Overflow-enabled form completes
  input wire logic ov_own_rule, // Multiply/divide own overflow rule
  input wire logic ov_own_val, // Overflow value under own rule
  input wire logic carry_in_msb, // Carry into result msb
  input wire logic carry_out_msb, // Carry out of result msb
  input wire logic ca_upd, // Carry-updating form completes
  input wire logic ca_own_rule, // Algebraic shift own carry rule
  input wire logic ca_own_val, // Carry value under own rule
  input wire logic rec_form, // Record form completes
  input wire logic mcrxr_en, // Move flags to condition field
  output logic [3:0] cond_field, // Copied summary/overflow/carry/zero
  output logic cond_valid, // Pulse with cond_field
  output logic cr0_so, // Summary copy for first condition field
  output logic cr0_valid, // Pulse with cr0_so
  output logic so_flag, // Sticky summary overflow
  output logic ov_flag, // Overflow
  output logic ca_flag, // Carry
  output logic [brs_pkg::TBC_W-1:0] string_byte_count // Byte count
);
  // Access is refused when user state writes any supervisor scratch word or reads scratch 0..3
  function automatic logic spr_denied(input logic [3:0] sel,
                                      input logic is_write,
                                      input logic umode);
    logic sup;
    sup = sel[3];
    spr_denied = umode && sup &&
      (is_write || sel < brs_pkg::SEL_SUP_SCRATCH_USER_RD);
  endfunction : spr_denied

  // Scratch word index for a select code, or out of range
  function automatic logic [brs_pkg::SCR_AW-1:0] scr_index(
      input logic [3:0] sel);
    logic [brs_pkg::SCR_AW-1:0] idx;
    idx = 4'hF;
    if (sel[3]) begin
      idx = {1'b0, sel[2:0]};
    end else if (sel == brs_pkg::SEL_USER_SCRATCH) begin
      idx = brs_pkg::SCR_USER_IDX;
    end
    scr_index = idx;
  endfunction : scr_index

  logic wr_ok;
  logic rd_ok;
  logic wr_ctr;
  logic wr_lr;
  logic wr_fx;
  logic scr_wr;
  logic scr_rd;
  logic [31:0] scr_rdata;

  // Request decode; user state may reach the branch and flag registers
  always_comb begin
    wr_ok = spr_wr_en && !spr_denied(spr_sel, 1'b1, user_mode);
    rd_ok = spr_rd_en && !spr_denied(spr_sel, 1'b0, user_mode);
    wr_ctr = wr_ok && spr_sel == brs_pkg::SEL_LOOP_COUNT;
    wr_lr = wr_ok && spr_sel == brs_pkg::SEL_RETURN_LINK;
    wr_fx = wr_ok && spr_sel == brs_pkg::SEL_FIXED_POINT_FLAGS;
    scr_wr = wr_ok && scr_index(spr_sel) != 4'hF;
    scr_rd = rd_ok && scr_index(spr_sel) != 4'hF;
  end

  // Scratch words live in their own store with registered read data
  brs_scratch_mem u_scratch (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(scr_wr),
    .wr_addr(scr_index(spr_sel)),
    .wr_data(spr_wdata),
    .rd_en(scr_rd),
    .rd_addr(scr_index(spr_sel)),
    .rd_data(scr_rdata)
  );

  logic [31:0] ctr_q, ctr_d;
  logic [31:0] lr_q, lr_d;
  logic [31:0] lr_tgt_q, lr_tgt_d;
  logic ctr_zero_q, ctr_zero_d;

  // Branch registers; a move-to in the same cycle wins over the branch
  always_comb begin
    ctr_d = ctr_q;
    lr_d = lr_q;
    if (wr_ctr) begin
      ctr_d = spr_wdata;
    end else if (br_dec_ctr) begin
      ctr_d = ctr_q - 32'h0000_0001;
    end
    if (wr_lr) begin
      lr_d = spr_wdata;
    end else if (br_link_en) begin
      lr_d = br_next_addr;
    end
    lr_tgt_d = {lr_d[31:brs_pkg::LINK_ALIGN_BITS],
                brs_pkg::LINK_ALIGN_BITS'(0)};
    ctr_zero_d = ctr_d == 32'h0000_0000;
  end

  // Reset gives a known value although software must not rely on it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctr_q <= brs_pkg::RST_WORD;
      lr_q <= brs_pkg::RST_WORD;
      lr_tgt_q <= brs_pkg::RST_WORD;
      ctr_zero_q <= 1'b1;
    end else begin
      ctr_q <= ctr_d;
      lr_q <= lr_d;
      lr_tgt_q <= lr_tgt_d;
      ctr_zero_q <= ctr_zero_d;
    end
  end

  logic so_q, so_d;
  logic ov_q, ov_d;
  logic ca_q, ca_d;
  logic [brs_pkg::TBC_W-1:0] tbc_q, tbc_d;
  logic [3:0] cond_q, cond_d;
  logic cond_v_q, cond_v_d;
  logic cr0_so_q, cr0_so_d;
  logic cr0_v_q, cr0_v_d;

  // Flags; an overflow in the clearing cycle still leaves summary set
  always_comb begin
    so_d = so_q;
    ov_d = ov_q;
    ca_d = ca_q;
    tbc_d = tbc_q;
    cond_d = cond_q;
    cond_v_d = 1'b0;
    if (mcrxr_en) begin
      cond_d = {so_q, ov_q, ca_q, 1'b0};
      cond_v_d = 1'b1;
      so_d = 1'b0;
      ov_d = 1'b0;
      ca_d = 1'b0;
    end
    if (wr_fx) begin
      so_d = spr_wdata[brs_pkg::FX_SO_BIT];
      ov_d = spr_wdata[brs_pkg::FX_OV_BIT];
      ca_d = spr_wdata[brs_pkg::FX_CA_BIT];
      tbc_d = spr_wdata[brs_pkg::FX_TBC_MSB:brs_pkg::FX_TBC_LSB];
    end
    if (ov_upd) begin
      if (ov_own_rule) begin
        ov_d = ov_own_val;
      end else begin
        ov_d = carry_in_msb ^ carry_out_msb;
      end
      if (ov_d) begin
        so_d = 1'b1;
      end
    end
    if (ca_upd) begin
      ca_d = ca_own_rule ? ca_own_val : carry_out_msb;
    end
    cr0_so_d = rec_form ? so_d : cr0_so_q;
    cr0_v_d = rec_form;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_q <= 1'b0;
      ov_q <= 1'b0;
      ca_q <= 1'b0;
      tbc_q <= brs_pkg::RST_TBC;
      cond_q <= 4'h0;
      cond_v_q <= 1'b0;
      cr0_so_q <= 1'b0;
      cr0_v_q <= 1'b0;
    end else begin
      so_q <= so_d;
      ov_q <= ov_d;
      ca_q <= ca_d;
      tbc_q <= tbc_d;
      cond_q <= cond_d;
      cond_v_q <= cond_v_d;
      cr0_so_q <= cr0_so_d;
      cr0_v_q <= cr0_v_d;
    end
  end

  logic s1_v_q, s1_v_d;
  logic s1_scr_q, s1_scr_d;
  logic [31:0] s1_word_q, s1_word_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic fault_q, fault_d;

  // Two-stage read so the scratch store and the port both stay registered
  always_comb begin
    s1_v_d = rd_ok;
    s1_scr_d = scr_rd;
    s1_word_d = 32'h0000_0000;
    unique case (spr_sel)
      brs_pkg::SEL_LOOP_COUNT: s1_word_d = ctr_q;
      brs_pkg::SEL_RETURN_LINK: s1_word_d = lr_q;
      brs_pkg::SEL_FIXED_POINT_FLAGS: begin
        s1_word_d[brs_pkg::FX_SO_BIT] = so_q;
        s1_word_d[brs_pkg::FX_OV_BIT] = ov_q;
        s1_word_d[brs_pkg::FX_CA_BIT] = ca_q;
        s1_word_d[brs_pkg::FX_TBC_MSB:brs_pkg::FX_TBC_LSB] = tbc_q;
      end
      default: s1_word_d = 32'h0000_0000;
    endcase
    rdata_d = rdata_q;
    if (s1_v_q) begin
      rdata_d = s1_scr_q ? scr_rdata : s1_word_q;
    end
    rvalid_d = s1_v_q;
    fault_d = (spr_wr_en || spr_rd_en) &&
      spr_denied(spr_sel, spr_wr_en, user_mode);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_v_q <= 1'b0;
      s1_scr_q <= 1'b0;
      s1_word_q <= brs_pkg::RST_WORD;
      rdata_q <= brs_pkg::RST_WORD;
      rvalid_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      s1_v_q <= s1_v_d;
      s1_scr_q <= s1_scr_d;
      s1_word_q <= s1_word_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      fault_q <= fault_d;
    end
  end

  // Every output straight from a flop
  assign spr_rdata = rdata_q;
  assign spr_rd_valid = rvalid_q;
  assign priv_fault = fault_q;
  assign ctr_target = ctr_q;
  assign link_target = lr_tgt_q;
  assign loop_count_zero = ctr_zero_q;
  assign cond_field = cond_q;
  assign cond_valid = cond_v_q;
  assign cr0_so = cr0_so_q;
  assign cr0_valid = cr0_v_q;
  assign so_flag = so_q;
  assign ov_flag = ov_q;
  assign ca_flag = ca_q;
  assign string_byte_count = tbc_q;

  // Summary overflow holds unless a legal clearing event occurs
  a_so_sticky_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    so_q && !wr_fx && !mcrxr_en |=> so_q)
    else $error("summary overflow cleared without cause");

  a_so_follows_ov: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ov_upd && !ov_own_rule && (carry_in_msb != carry_out_msb)
    |=> ov_q && so_q)
    else $error("overflow did not set summary");

  a_ov_xor_rule: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ov_upd && !ov_own_rule
    |=> ov_q == ($past(carry_in_msb) ^ $past(carry_out_msb)))
    else $error("overflow not carry xor");

  a_ca_carry_out: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ca_upd && !ca_own_rule |=> ca_q == $past(carry_out_msb))
    else $error("carry not msb carry out");

  a_mcrxr_copy_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    mcrxr_en && !wr_fx && !ov_upd && !ca_upd
    |=> cond_valid && cond_q == {$past(so_q), $past(ov_q), $past(ca_q), 1'b0}
        && !so_q && !ov_q && !ca_q)
    else $error("flag copy or clear wrong");

  a_link_load_next: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    br_link_en && !wr_lr
    |=> lr_q == $past(br_next_addr) ##1 link_target[1:0] == 2'h0)
    else $error("return link not loaded");

  a_ctr_decrement: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    br_dec_ctr && !wr_ctr |=> ctr_target == $past(ctr_target) - 32'h1)
    else $error("loop count not decremented");

  a_priv_fault_block: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    spr_wr_en && user_mode && spr_sel[3] |=> priv_fault ##1 !spr_rd_valid)
    else $error("user write to supervisor scratch not faulted");

  a_read_two_cycles: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    spr_rd_en && spr_sel == brs_pkg::SEL_LOOP_COUNT && !spr_wr_en
    |=> ##1 spr_rd_valid && spr_rdata == $past(ctr_q, 2))
    else $error("loop count read wrong");
endmodule : brs_branch_fx_sprs

// ===== src/brs_pkg.sv
package brs_pkg;
  // Register select codes carried by move-to / move-from requests
  localparam logic [3:0] SEL_LOOP_COUNT = 4'h0;
  localparam logic [3:0] SEL_RETURN_LINK = 4'h1;
  localparam logic [3:0] SEL_FIXED_POINT_FLAGS = 4'h2;
  localparam logic [3:0] SEL_USER_SCRATCH = 4'h3;
  localparam logic [3:0] SEL_SUP_SCRATCH_BASE = 4'h8;
  // Supervisor scratch 4..7 are user readable
  localparam logic [3:0] SEL_SUP_SCRATCH_USER_RD = 4'hC;
  // Flags register layout; printed bit 0 is the msb, so bit n is 31-n here
  localparam int FX_SO_BIT = 31;
  localparam int FX_OV_BIT = 30;
  localparam int FX_CA_BIT = 29;
  localparam int FX_TBC_MSB = 6;
  localparam int FX_TBC_LSB = 0;
  localparam int TBC_W = 7;
  // Word alignment of a return address
  localparam int LINK_ALIGN_BITS = 2;
  // Scratch store: eight supervisor words then the user word
  localparam int SCR_DEPTH = 9;
  localparam int SCR_AW = 4;
  localparam logic [3:0] SCR_USER_IDX = 4'h8;
  // Reset values chosen for determinism
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [TBC_W-1:0] RST_TBC = 7'h00;
endpackage : brs_pkg

// ===== src/brs_scratch_mem.sv
`timescale 1ns/100ps
module brs_scratch_mem (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [brs_pkg::SCR_AW-1:0] wr_addr, // Write word index
  input wire logic [31:0] wr_data, // Write data
  input wire logic rd_en, // Read strobe
  input wire logic [brs_pkg::SCR_AW-1:0] rd_addr, // Read word index
  output logic [31:0] rd_data // Registered read data
);
  logic [31:0] mem_q [brs_pkg::SCR_DEPTH];
  logic [31:0] mem_d [brs_pkg::SCR_DEPTH];
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;

  // Next word values; only software writes ever land here
  for (genvar i = 0; i < brs_pkg::SCR_DEPTH; i++) begin : g_word
    always_comb begin
      mem_d[i] = mem_q[i];
      if (wr_en && wr_addr == brs_pkg::SCR_AW'(i)) begin
        mem_d[i] = wr_data;
      end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= brs_pkg::RST_WORD;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // Read port holds its last word between reads
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en && rd_addr < brs_pkg::SCR_AW'(brs_pkg::SCR_DEPTH)) begin
      rd_data_d = mem_q[rd_addr];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= brs_pkg::RST_WORD;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;
endmodule : brs_scratch_mem
